// [src/smr_pkg.sv]
/*
  Constants and types shared by the synchronous master serial receiver:
  register offsets, bit positions, reset values, character sizes and the
  shift state encoding.
  Assumes an 8-bit register port with a 3-bit word address.
*/
`default_nettype none

package smr_pkg;

  // Register word addresses.
  localparam logic [2:0] ADDR_STATUS = 3'h0;  // Receive status and control.
  localparam logic [2:0] ADDR_DATA   = 3'h1;  // Receive data, pops on read.
  localparam logic [2:0] ADDR_BRG_LO = 3'h2;  // Baud divisor low byte.
  localparam logic [2:0] ADDR_BRG_HI = 3'h3;  // Baud divisor high byte.
  localparam logic [2:0] ADDR_MODE   = 3'h4;  // Master and counter mode bits.
  localparam logic [2:0] ADDR_PIE    = 3'h5;  // Peripheral interrupt enables.
  localparam logic [2:0] ADDR_PIR    = 3'h6;  // Peripheral interrupt flags.
  localparam logic [2:0] ADDR_GIC    = 3'h7;  // Global interrupt control.

  // Bit positions inside the status and control register.
  localparam int BIT_SERIAL_PORT_ENABLE  = 7;  // Serial port enable.
  localparam int BIT_NINE  = 6;  // Nine-bit receive enable.
  localparam int BIT_SINGLE_RECEIVE_ENABLE  = 5;  // Single receive enable.
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE  = 4;  // Continuous receive enable.
  localparam int BIT_OVERRUN_ERROR_FLAG  = 1;  // Overrun error flag.
  localparam int BIT_NINTH = 0;  // Received ninth bit.
  // Bit positions of the other registers.
  localparam int BIT_CLOCK_SOURCE_MASTER_SELECT  = 7;  // Clock source master select.
  localparam int BIT_WIDE  = 3;  // Wide baud counter select.
  localparam int BIT_HSPD  = 2;  // High speed baud select.
  localparam int BIT_RECEIVE_INTERRUPT_ENABLE  = 5;  // Receive interrupt enable.
  localparam int BIT_RECEIVE_PENDING_FLAG  = 5;  // Receive pending flag.
  localparam int BIT_GIE   = 7;  // Global interrupt enable.
  localparam int BIT_PERIPHERAL_INTERRUPT_ENABLE  = 6;  // Peripheral interrupt enable.

  // Reset values.
  localparam logic [7:0] RST_REG  = 8'h00;  // Every control register.
  localparam logic [7:0] RST_BYTE = 8'h00;  // Read data and divisor bytes.

  // Character sizes in bits and FIFO depth.
  localparam logic [3:0] CHAR_BITS_8 = 4'h8;
  localparam logic [3:0] CHAR_BITS_9 = 4'h9;
  localparam logic [1:0] FIFO_DEPTH  = 2'h2;

  // Shift engine states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // No clock issued, line idles low.
    ST_HIGH = 2'b01,  // Leading half of a bit clock.
    ST_LOW  = 2'b10   // Trailing half of a bit clock.
  } smr_state_t;

endpackage

`default_nettype wire

// [src/smr_sync.sv]
/*
  Two flip-flop synchroniser for levels entering the core clock domain.
  Assumes the input changes no faster than a few core clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module smr_sync #(
  parameter int W = 1  // Number of independent levels.
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;  // First stage, read only by the second stage.

  // The clock enable is deliberately not applied here so that the pin
  // value is fresh the moment the core is enabled again.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule // smr_sync

`default_nettype wire

// [src/smr_fifo.sv]
/*
  Two-entry receive FIFO. Holds whole characters; the head is always
  visible. A push into a full FIFO is ignored and never overwrites.
  Assumes push and pop are single-cycle requests on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module smr_fifo
  import smr_pkg::*;
#(
  parameter int W = 9  // Character width including the ninth bit.
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         ce_i,
  input  wire logic         flush_i,
  input  wire logic         push_i,
  input  wire logic [W-1:0] din_i,
  input  wire logic         pop_i,
  output var  logic [W-1:0] head_o,
  output var  logic         empty_o,
  output var  logic         full_o
);

  logic [W-1:0] mem_r   [2];  // Character storage.
  logic [W-1:0] mem_nxt [2];
  logic         rp_r;         // Index of the oldest character.
  logic         rp_nxt;
  logic [1:0]   cnt_r;        // Characters held, 0 to 2.
  logic [1:0]   cnt_nxt;
  logic         push_ok;      // Push that finds room.
  logic         pop_ok;       // Pop that finds data.

  // Next state: a flush beats everything, full refuses the push.
  always_comb begin
    mem_nxt = mem_r;
    push_ok = push_i && !full_o;
    pop_ok  = pop_i && !empty_o;
    rp_nxt  = rp_r;
    cnt_nxt = cnt_r;
    if (flush_i) begin
      rp_nxt  = 1'b0;
      cnt_nxt = 2'h0;
    end else begin
      if (push_ok) begin
        mem_nxt[rp_r ^ cnt_r[0]] = din_i;
      end
      if (pop_ok) begin
        rp_nxt = ~rp_r;
      end
      cnt_nxt = cnt_r + {1'b0, push_ok} - {1'b0, pop_ok};
    end
  end

  // Registers, frozen while the clock enable is low.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_r <= '{default: '0};
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else if (ce_i) begin
      mem_r <= mem_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign head_o  = mem_r[rp_r];
  assign empty_o = (cnt_r == 2'h0);
  assign full_o  = (cnt_r == FIFO_DEPTH);

endmodule // smr_fifo

`default_nettype wire

// [src/smr_top.sv]
/*
  Synchronous master serial receiver. Drives the shift clock, samples
  the data pin on the trailing clock edge, stores whole characters of 8
  or 9 bits in a two-entry FIFO and flags overrun.
  Assumes a single-cycle register port, a slave that changes data on the
  rising clock edge, and a half bit period of at least three core clocks
  so the synchronised data is settled at the sampling point.
*/
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none

module smr_top
  import smr_pkg::*;
#(
  parameter int CW = 16  // Width of the half-period counter.
) (
  input  wire logic       CLK_I,
  input  wire logic       ARST_N_I,
  input  wire logic       CE_I,
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output var  logic [7:0] RDATA_O,
  output var  logic       IRQ_O,
  output var  logic       SCLK_O,
  output var  logic       SCLK_OE_O,
  input  wire logic       SDATA_I,
  output var  logic       SDATA_O,
  output var  logic       SDATA_OE_O
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic          serial_port_enable_r, serial_port_enable_nxt;      // Serial port enable.
  logic          nine_r, nine_nxt;      // Nine-bit receive enable.
  logic          single_receive_enable_r, single_receive_enable_nxt;      // Single receive enable.
  logic          continuous_receive_enable_r, continuous_receive_enable_nxt;      // Continuous receive enable.
  logic          clock_source_master_select_r, clock_source_master_select_nxt;      // Master clock source select.
  logic          wide_r, wide_nxt;      // Sixteen-bit divisor select.
  logic          hspd_r, hspd_nxt;      // Stored only; no effect when synchronous.
  logic [7:0]    brg_lo_r, brg_lo_nxt;  // Divisor low byte.
  logic [7:0]    brg_hi_r, brg_hi_nxt;  // Divisor high byte.
  logic          receive_interrupt_enable_r, receive_interrupt_enable_nxt;      // Receive interrupt enable.
  logic          gie_r, gie_nxt;        // Global interrupt enable.
  logic          peripheral_interrupt_enable_r, peripheral_interrupt_enable_nxt;      // Peripheral interrupt enable.

  smr_state_t    st_r, st_nxt;          // Shift engine state.
  logic [CW-1:0] cnt_r, cnt_nxt;        // Half-period countdown.
  logic [3:0]    bits_r, bits_nxt;      // Bits sampled so far.
  logic [8:0]    rsr_r, rsr_nxt;        // Receive shift register.
  logic          sclk_r, sclk_nxt;      // Shift clock level.

  logic          overrun_error_flag_r, overrun_error_flag_nxt;      // Overrun error flag.
  logic          ovcont_r, ovcont_nxt;  // Overrun happened in continuous mode.
  logic          irq_r, irq_nxt;        // Interrupt request.
  logic [7:0]    rdata_r, rdata_nxt;    // Read data, valid one cycle.
  logic          oe_r, oe_nxt;          // Clock pin driver enable.
  logic          dout_r;                // Data pin driver, idle in receive.

  logic          sdat_s;                // Synchronised data pin.
  logic          run;                   // Reception requested and allowed.
  logic          cmp;                   // A character completes this cycle.
  logic [CW-1:0] div;                   // Selected half-period reload.
  logic [3:0]    nbits;                 // Bits per character.
  logic [8:0]    chr;                   // Completed character, LSB aligned.
  logic          rd_data;               // Read of the data register.
  logic          wr_stat;               // Write of the status register.
  logic [8:0]    head;                  // Oldest unread character.
  logic          empty, full;           // FIFO occupancy.

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser and FIFO.

  // The data pin is asynchronous to the core clock.
  smr_sync #(.W(1)) u_sync (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .d_i      (SDATA_I),
    .q_o      (sdat_s)
  );

  // Completed characters are refused while overrun stands.
  smr_fifo #(.W(9)) u_fifo (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .ce_i     (CE_I),
    .flush_i  (!serial_port_enable_r),
    .push_i   (cmp && !overrun_error_flag_r),
    .din_i    (chr),
    .pop_i    (rd_data),
    .head_o   (head),
    .empty_o  (empty),
    .full_o   (full)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register writes.

  assign rd_data = RD_I && (ADDR_I == ADDR_DATA);
  assign wr_stat = WR_I && (ADDR_I == ADDR_STATUS);

  // Software writes; completion of a character clears single receive,
  // and that clear wins over a write in the same cycle.
  always_comb begin
    serial_port_enable_nxt   = serial_port_enable_r;
    nine_nxt   = nine_r;
    single_receive_enable_nxt   = single_receive_enable_r;
    continuous_receive_enable_nxt   = continuous_receive_enable_r;
    clock_source_master_select_nxt   = clock_source_master_select_r;
    wide_nxt   = wide_r;
    hspd_nxt   = hspd_r;
    brg_lo_nxt = brg_lo_r;
    brg_hi_nxt = brg_hi_r;
    receive_interrupt_enable_nxt   = receive_interrupt_enable_r;
    gie_nxt    = gie_r;
    peripheral_interrupt_enable_nxt   = peripheral_interrupt_enable_r;
    if (!WR_I) begin
      // Nothing written.
    end else if (ADDR_I == ADDR_STATUS) begin
      // Overrun and ninth bit are not writable.
      serial_port_enable_nxt = WDATA_I[BIT_SERIAL_PORT_ENABLE];
      nine_nxt = WDATA_I[BIT_NINE];
      single_receive_enable_nxt = WDATA_I[BIT_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable_nxt = WDATA_I[BIT_CONTINUOUS_RECEIVE_ENABLE];
    end else if (ADDR_I == ADDR_BRG_LO) begin
      brg_lo_nxt = WDATA_I;
    end else if (ADDR_I == ADDR_BRG_HI) begin
      brg_hi_nxt = WDATA_I;
    end else if (ADDR_I == ADDR_MODE) begin
      clock_source_master_select_nxt = WDATA_I[BIT_CLOCK_SOURCE_MASTER_SELECT];
      wide_nxt = WDATA_I[BIT_WIDE];
      hspd_nxt = WDATA_I[BIT_HSPD];
    end else if (ADDR_I == ADDR_PIE) begin
      receive_interrupt_enable_nxt = WDATA_I[BIT_RECEIVE_INTERRUPT_ENABLE];
    end else if (ADDR_I == ADDR_GIC) begin
      gie_nxt  = WDATA_I[BIT_GIE];
      peripheral_interrupt_enable_nxt = WDATA_I[BIT_PERIPHERAL_INTERRUPT_ENABLE];
    end
    if (cmp) begin
      single_receive_enable_nxt = 1'b0;
    end
  end

  // Control registers.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      {serial_port_enable_r, nine_r, single_receive_enable_r, continuous_receive_enable_r, clock_source_master_select_r, wide_r, hspd_r} <= RST_REG[6:0];
      brg_lo_r <= RST_BYTE;
      brg_hi_r <= RST_BYTE;
      {receive_interrupt_enable_r, gie_r, peripheral_interrupt_enable_r} <= RST_REG[2:0];
    end else if (CE_I) begin
      {serial_port_enable_r, nine_r, single_receive_enable_r, continuous_receive_enable_r} <= {serial_port_enable_nxt, nine_nxt, single_receive_enable_nxt, continuous_receive_enable_nxt};
      {clock_source_master_select_r, wide_r, hspd_r} <= {clock_source_master_select_nxt, wide_nxt, hspd_nxt};
      brg_lo_r <= brg_lo_nxt;
      brg_hi_r <= brg_hi_nxt;
      {receive_interrupt_enable_r, gie_r, peripheral_interrupt_enable_r} <= {receive_interrupt_enable_nxt, gie_nxt, peripheral_interrupt_enable_nxt};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shift engine.

  assign div   = wide_r ? CW'({brg_hi_r, brg_lo_r}) : CW'(brg_lo_r);
  assign nbits = nine_r ? CHAR_BITS_9 : CHAR_BITS_8;
  assign run   = serial_port_enable_r && clock_source_master_select_r && (single_receive_enable_r || continuous_receive_enable_r);
  // Bits arrive LSB first and enter at the top, so eight-bit data ends up
  // one place high and is shifted down on completion.
  assign chr   = nine_r ? rsr_r : {1'b0, rsr_r[8:1]};

  // Rising edge is the leading edge, falling edge samples the pin.
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    bits_nxt = bits_r;
    rsr_nxt  = rsr_r;
    sclk_nxt = sclk_r;
    cmp      = 1'b0;
    if (!run) begin
      // Losing both enables mid-character drops the partial character.
      st_nxt   = ST_IDLE;
      sclk_nxt = 1'b0;
      bits_nxt = 4'h0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (!overrun_error_flag_r) begin
            st_nxt   = ST_HIGH;
            sclk_nxt = 1'b1;
            cnt_nxt  = div;
            bits_nxt = 4'h0;
          end
        end
        ST_HIGH: begin
          if (cnt_r == '0) begin
            st_nxt   = ST_LOW;
            sclk_nxt = 1'b0;
            rsr_nxt  = {sdat_s, rsr_r[8:1]};
            bits_nxt = bits_r + 4'h1;
            cnt_nxt  = div;
          end else begin
            cnt_nxt = cnt_r - CW'(1);
          end
        end
        ST_LOW: begin
          if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
          end else if (bits_r == nbits) begin
            // Whole character in; continuous mode restarts from idle.
            st_nxt = ST_IDLE;
            cmp    = 1'b1;
          end else begin
            st_nxt   = ST_HIGH;
            sclk_nxt = 1'b1;
            cnt_nxt  = div;
          end
        end
        default: begin
          st_nxt   = ST_IDLE;
          sclk_nxt = 1'b0;
        end
      endcase
    end
  end

  // Shift engine registers.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r   <= ST_IDLE;
      cnt_r  <= '0;
      bits_r <= 4'h0;
      rsr_r  <= 9'h000;
      sclk_r <= 1'b0;
    end else if (CE_I) begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      bits_r <= bits_nxt;
      rsr_r  <= rsr_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overrun, interrupt, read data and pin drivers.

  // Clear first, then set, so a new overrun is never lost to a clear.
  always_comb begin
    overrun_error_flag_nxt   = overrun_error_flag_r;
    ovcont_nxt = ovcont_r;
    if (!serial_port_enable_r) begin
      overrun_error_flag_nxt = 1'b0;
    end else if (ovcont_r ? !continuous_receive_enable_r : rd_data) begin
      overrun_error_flag_nxt = 1'b0;
    end
    if (cmp && full && !overrun_error_flag_r) begin
      overrun_error_flag_nxt   = 1'b1;
      ovcont_nxt = continuous_receive_enable_r;
    end
    // Pending follows FIFO occupancy; the request needs all enables.
    irq_nxt = !empty && receive_interrupt_enable_r && gie_r && peripheral_interrupt_enable_r;
    oe_nxt  = serial_port_enable_r && clock_source_master_select_r;
    rdata_nxt = RST_BYTE;
    if (!RD_I) begin
      rdata_nxt = RST_BYTE;
    end else if (ADDR_I == ADDR_STATUS) begin
      rdata_nxt = {serial_port_enable_r, nine_r, single_receive_enable_r, continuous_receive_enable_r, 2'b00,
                   overrun_error_flag_r, head[8]};
    end else if (ADDR_I == ADDR_DATA) begin
      rdata_nxt = head[7:0];
    end else if (ADDR_I == ADDR_BRG_LO) begin
      rdata_nxt = brg_lo_r;
    end else if (ADDR_I == ADDR_BRG_HI) begin
      rdata_nxt = brg_hi_r;
    end else if (ADDR_I == ADDR_MODE) begin
      rdata_nxt = {clock_source_master_select_r, 3'b000, wide_r, hspd_r, 2'b00};
    end else if (ADDR_I == ADDR_PIE) begin
      rdata_nxt = {2'b00, receive_interrupt_enable_r, 5'h00};
    end else if (ADDR_I == ADDR_PIR) begin
      rdata_nxt = {2'b00, !empty, 5'h00};
    end else begin
      rdata_nxt = {gie_r, peripheral_interrupt_enable_r, 6'h00};
    end
  end

  // Status registers and registered outputs.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      overrun_error_flag_r   <= 1'b0;
      ovcont_r <= 1'b0;
      irq_r    <= 1'b0;
      rdata_r  <= RST_BYTE;
      oe_r     <= 1'b0;
      dout_r   <= 1'b0;
    end else if (CE_I) begin
      overrun_error_flag_r   <= overrun_error_flag_nxt;
      ovcont_r <= ovcont_nxt;
      irq_r    <= irq_nxt;
      rdata_r  <= rdata_nxt;
      oe_r     <= oe_nxt;
      dout_r   <= 1'b0;
    end
  end

  assign RDATA_O    = rdata_r;
  assign IRQ_O      = irq_r;
  assign SCLK_O     = sclk_r;
  assign SCLK_OE_O  = oe_r;
  assign SDATA_O    = dout_r;
  assign SDATA_OE_O = dout_r;

  ////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  ovr_set_a: assert property (CE_I && cmp && full |=> overrun_error_flag_r)
    else $error("overrun not flagged");
  ovr_keep_a: assert property (CE_I && cmp && full && !rd_data |=> $stable(head))
    else $error("stored character changed on overrun");
  ovr_block_a: assert property (overrun_error_flag_r && CE_I && serial_port_enable_r && !rd_data |=> $stable(u_fifo.cnt_r))
    else $error("character accepted during overrun");
  ovr_hold_a: assert property (CE_I && overrun_error_flag_r && ovcont_r && continuous_receive_enable_r && serial_port_enable_r |=> overrun_error_flag_r)
    else $error("overrun cleared without cause");
  ovr_rdclr_a: assert property (CE_I && overrun_error_flag_r && !ovcont_r && rd_data |=> !overrun_error_flag_r)
    else $error("data read did not clear overrun");
  ovr_crclr_a: assert property (CE_I && overrun_error_flag_r && ovcont_r && !continuous_receive_enable_r |=> !overrun_error_flag_r)
    else $error("continuous disable did not clear overrun");
  ninth_rd_a: assert property (CE_I && RD_I && ADDR_I == ADDR_STATUS && !cmp && serial_port_enable_r
    |=> RDATA_O[BIT_NINTH] == $past(head[8]) && !$past(empty) == !empty)
    else $error("ninth bit wrong or status read popped");
  data_rd_a: assert property (CE_I && rd_data |=> RDATA_O == $past(head[7:0]))
    else $error("data read returned wrong byte");
  pend_irq_a: assert property (CE_I && cmp && !overrun_error_flag_r && receive_interrupt_enable_r && gie_r && peripheral_interrupt_enable_r
    && !rd_data && !WR_I ##1 CE_I |=> IRQ_O)
    else $error("interrupt missing after completion");
  single_receive_enable_clr_a: assert property (CE_I && cmp |=> !single_receive_enable_r)
    else $error("single receive not cleared");
  abort_a: assert property (CE_I && st_r != ST_IDLE && !single_receive_enable_r && !continuous_receive_enable_r
    |=> st_r == ST_IDLE && !SCLK_O)
    else $error("clock not stopped on disable");
  serial_port_enable_off_a: assert property (CE_I && !serial_port_enable_r |=> empty && !overrun_error_flag_r)
    else $error("port disable did not reset receiver");
  ovr_quiet_a: assert property (overrun_error_flag_r && st_r == ST_IDLE |=> st_r == ST_IDLE)
    else $error("clock started during overrun");

  single_c: cover property (cmp && !continuous_receive_enable_r);
  cont_two_c: cover property (cmp && continuous_receive_enable_r ##[1:400] cmp);
  overrun_c: cover property (CE_I && cmp && full);
  nine_c: cover property (cmp && nine_r);

endmodule // smr_top

`default_nettype wire

// [dv/smr_slave_model.sv]
/*
  Behavioural synchronous slave that feeds characters to the receiver.
  Assumes the master clock idles low and is seen through the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module smr_slave_model (
  input  wire logic       clk_i,
  input  wire logic       clr_i,
  input  wire logic       sclk_i,
  input  wire logic       nine_i,
  input  wire logic [8:0] char_i,
  output var  logic       sdata_o
);
  logic [3:0] idx_r;   // Bit index inside the character.
  logic [8:0] sr_r;    // Character latched at its first bit.
  logic       sclk_q;  // Last seen clock level, for edge finding.

  // Bits change on the leading edge so they are steady at the trailing one.
  always @(posedge clk_i) begin
    sclk_q <= sclk_i;
    if (clr_i) begin
      idx_r <= 4'h0;
    end else if (sclk_i && !sclk_q) begin
      sdata_o <= (idx_r == 4'h0) ? char_i[0] : sr_r[idx_r];
      if (idx_r == 4'h0) begin
        sr_r <= char_i;
      end
      idx_r <= (idx_r == (nine_i ? 4'h8 : 4'h7)) ? 4'h0 : idx_r + 4'h1;
    end else if (!sclk_i && sclk_q && idx_r == 4'h0) begin
      sdata_o <= ~sdata_o;  // Hold time over, so the old level is not kept.
    end
  end

  initial begin
    idx_r = 4'h0;
    sr_r = 9'h000;
    sclk_q = 1'b0;
    sdata_o = 1'b0;
  end
endmodule  // smr_slave_model

`default_nettype wire

// [dv/smr_top_test.sv]
/*
  Self-checking bench of the master receiver, with a slave model.
  Assumes a 250 MHz core clock and a link clock near 125 ns.
*/
`timescale 1ns/1ps
`default_nettype none

module smr_top_test;
  import smr_pkg::*;
  localparam int DIV = 15;  // Half bit of 16 cycles, link period 128 ns.
  logic       clk, arst_n, wr, rds, nine, clr, sdi, irq, sclk, oe, so, soe, hi;
  logic       ce;  // Clock enable driven into the design.
  logic [2:0] addr;
  logic [7:0] wd, rdat, r;
  logic [8:0] ch;
  logic [8:0] q [3];
  logic [31:0] seed;
  int          fails, comparisons;

  smr_top #(.CW(16)) u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce),
    .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr), .RD_I(rds), .RDATA_O(rdat),
    .IRQ_O(irq), .SCLK_O(sclk), .SCLK_OE_O(oe), .SDATA_I(sdi),
    .SDATA_O(so), .SDATA_OE_O(soe));
  smr_slave_model u_slave (.clk_i(clk), .clr_i(clr), .sclk_i(sclk),
    .nine_i(nine), .char_i(ch), .sdata_o(sdi));

  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [2:0] a);
    @(posedge clk);
    rds <= 1'b1;
    addr <= a;
    @(posedge clk);
    rds <= 1'b0;
    #1 r = rdat;
  endtask
  // Counts trailing clock edges, then waits past the character's end.
  task automatic rx(input int n);
    int f;
    int t;
    logic p;
    f = 0;
    for (t = 0; t < 20000 && f < n; t++) begin
      p = sclk;
      @(posedge clk);
      #1 if (p && !sclk) f++;
    end
    repeat (DIV + 10) @(posedge clk);
  endtask
  task automatic quiet(input int n);
    hi = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1 hi = hi | sclk;
    end
  endtask
  task automatic newch;
    seed = xs(seed);
    ch <= seed[8:0];
    @(posedge clk);
  endtask
  task automatic end_sim;
    if (fails == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    fails++;
    end_sim;
  end

  // Main sequence: reset values, single, overrun, continuous, abort.
  initial begin
    arst_n = 1'b0; wr = 1'b0; rds = 1'b0; addr = 3'h0; wd = 8'h00;
    nine = 1'b0; clr = 1'b0; ch = 9'h000; seed = 32'hCBF6DD60; ce = 1'b1;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rdr(3'(a));
      chk("reset", {1'b0, RST_REG}, {1'b0, r});
    end
    // A write while the clock enable is low must leave the register alone.
    ce <= 1'b0;
    wrr(ADDR_BRG_LO, 8'h55);
    ce <= 1'b1;
    rdr(ADDR_BRG_LO);
    chk("ce", 9'h000, {1'b0, r});
    wrr(ADDR_BRG_LO, 8'(DIV));
    wrr(ADDR_MODE, 8'h80);
    wrr(ADDR_PIE, 8'h20);
    wrr(ADDR_GIC, 8'hC0);
    for (int i = 0; i < 4; i++) begin
      nine <= i[0];
      newch;
      wrr(ADDR_STATUS, i[0] ? 8'hE0 : 8'hA0);
      rx(8 + i % 2);
      chk("irq", 9'h001, {8'h00, irq});
      rdr(ADDR_STATUS);
      chk("st", i[0] ? 9'h0C0 | ch[8] : 9'h080, r & (i[0] ? 8'hFF : 8'hFE));
      rdr(ADDR_DATA);
      chk("data", {1'b0, ch[7:0]}, {1'b0, r});
      repeat (2) @(posedge clk);
      chk("irq", 9'h000, {8'h00, irq});
    end
    nine <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      newch;
      q[i] = seed[8:0];
      wrr(ADDR_STATUS, 8'hE0);
      rx(9);
    end
    wrr(ADDR_STATUS, 8'hC0);
    rdr(ADDR_STATUS);
    chk("ovr", 9'h0C2 | q[0][8], {1'b0, r});
    rdr(ADDR_DATA);
    chk("data", {1'b0, q[0][7:0]}, {1'b0, r});
    rdr(ADDR_STATUS);
    chk("ovr", 9'h0C0 | q[1][8], {1'b0, r});
    rdr(ADDR_DATA);
    chk("data", {1'b0, q[1][7:0]}, {1'b0, r});
    rdr(ADDR_PIR);
    chk("pend", 9'h000, {1'b0, r});
    nine <= 1'b0;
    newch;
    wrr(ADDR_STATUS, 8'h90);
    rx(24);
    quiet(300);
    chk("sclk", 9'h000, {8'h00, hi});
    rdr(ADDR_DATA);
    chk("data", {1'b0, ch[7:0]}, {1'b0, r});
    rdr(ADDR_STATUS);
    chk("ovr", 9'h092, {1'b0, r & 8'hFE});
    wrr(ADDR_STATUS, 8'h80);
    rdr(ADDR_STATUS);
    chk("ovr", 9'h080, {1'b0, r & 8'hFE});
    rdr(ADDR_DATA);
    chk("data", {1'b0, ch[7:0]}, {1'b0, r});
    newch;
    wrr(ADDR_STATUS, 8'hB0);
    rx(11);
    wrr(ADDR_STATUS, 8'h80);
    rdr(ADDR_STATUS);
    chk("both", 9'h080, {1'b0, r & 8'hFE});
    quiet(100);
    chk("sclk", 9'h000, {8'h00, hi});
    rdr(ADDR_DATA);
    chk("data", {1'b0, ch[7:0]}, {1'b0, r});
    rdr(ADDR_PIR);
    chk("pend", 9'h000, {1'b0, r});
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    newch;
    wrr(ADDR_STATUS, 8'hA0);
    rx(8);
    wrr(ADDR_GIC, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq", 9'h000, {8'h00, irq});
    wrr(ADDR_GIC, 8'hC0);
    wrr(ADDR_STATUS, 8'h00);
    rdr(ADDR_PIR);
    chk("pend", 9'h000, {1'b0, r});
    chk("oe", 9'h000, {8'h00, oe});
    chk("sdo", 9'h000, {7'h00, so, soe});
    end_sim;
  end
endmodule  // smr_top_test

`default_nettype wire
